// file: logic/pfp_filter.sv
// Package of shared constants and the per-input debounce filter.
package pfp_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int PFP_NUM_IN   = 6;
  localparam int PFP_NUM_OUT  = 4;
  localparam int PFP_NUM_TRIG = 8;
  localparam int PFP_NUM_FILT = 15;
  localparam int PFP_NUM_DEST = 24;
  localparam int PFP_CW       = 17;
  // ----------------------------------------------------------------
  // Filter settings and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] PFP_FILT_OFF   = 2'h0;
  localparam logic [1:0] PFP_FILT_SHORT = 2'h1;
  localparam logic [1:0] PFP_FILT_MID   = 2'h2;
  localparam logic [1:0] PFP_FILT_LONG  = 2'h3;
  localparam int PFP_CLK_MHZ     = 40;
  localparam int PFP_SHORT_NS    = 125;
  localparam int PFP_MID_NS      = 6425;
  localparam int PFP_SHORT_N     = (PFP_SHORT_NS * PFP_CLK_MHZ) / 1000;
  localparam int PFP_MID_N       = (PFP_MID_NS * PFP_CLK_MHZ) / 1000;
  localparam int PFP_LONG_N      = 101800;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] PFP_IN_MODE_OFF    = 12'h000;
  localparam logic [11:0] PFP_IN_FILT_OFF    = 12'h004;
  localparam logic [11:0] PFP_TRIG_FILT_OFF  = 12'h008;
  localparam logic [11:0] PFP_OUT_CTRL_OFF   = 12'h00C;
  localparam logic [11:0] PFP_OUT_SEL_OFF    = 12'h010;
  localparam logic [11:0] PFP_TRIG_ROUTE_OFF = 12'h014;
  localparam logic [11:0] PFP_STATUS_OFF     = 12'h018;
  localparam logic [11:0] PFP_POWERUP_OFF    = 12'h01C;
  localparam logic [11:0] PFP_DEST_BASE      = 12'h100;
  // Destination entry fields.
  localparam int PFP_DEST_SRC_LSB = 0;
  localparam int PFP_DEST_INV_BIT = 4;
  localparam int PFP_DEST_EDG_BIT = 5;
  localparam int PFP_DEST_EN_BIT  = 6;
  localparam int PFP_DEST_W       = 7;
  localparam int PFP_OSEL_W       = 5;
  localparam int PFP_TRT_W        = 4;
  localparam int PFP_TRT_EN_BIT   = 3;
  localparam int PFP_TRT_PIN_W    = 3;
  // Output source codes.
  localparam logic [4:0] PFP_OSRC_HOLD = 5'h00;
  localparam logic [4:0] PFP_OSRC_FREQ = 5'h07;
  localparam logic [4:0] PFP_OSRC_STAR = 5'h08;
  localparam logic [4:0] PFP_OSRC_TRIG = 5'h09;
  localparam logic [31:0] PFP_RESET_VAL = 32'h0000_0000;
endpackage

module pfp_filter
  import pfp_pkg::*;
#(
  parameter int              CW      = PFP_CW,
  parameter logic [CW-1:0]   SHORT_N = CW'(PFP_SHORT_N),
  parameter logic [CW-1:0]   MID_N   = CW'(PFP_MID_N),
  parameter logic [CW-1:0]   LONG_N  = CW'(PFP_LONG_N)
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          din,
  input  wire logic [1:0]    setting,
  output logic               dout
);
  logic          sync1_reg;
  logic          sync2_reg;
  logic [CW-1:0] count_reg;
  wire logic [CW-1:0] n_sel = (setting == PFP_FILT_SHORT) ? SHORT_N :
                              (setting == PFP_FILT_MID)   ? MID_N : LONG_N;
  wire logic          differs = sync2_reg != dout;
  wire logic          last    = count_reg == n_sel - CW'(1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      count_reg <= '0;
      dout      <= 1'b0;
    end else begin
      sync1_reg <= din;                 // [RULE_16]
      sync2_reg <= sync1_reg;
      if (setting == PFP_FILT_OFF) begin
        dout      <= sync2_reg;
        count_reg <= '0;
      end else if (!differs) begin
        count_reg <= '0;                // [RULE_16]
      end else if (last) begin
        dout      <= sync2_reg;         // [RULE_09]
        count_reg <= '0;
      end else begin
        count_reg <= count_reg + CW'(1); // [RULE_08]
      end
    end
  end
endmodule

// file: logic/pfp_top.sv
// Programmable function pin block: routing, static bits, filters, APB registers.
//
// The placing of the registers and register access over APB were chosen for this implementation.

// Function
// RULE_01: Ten pins: six inputs, four outputs.
// RULE_02: Input pin is timing or static input.
// RULE_03: Output pin is timing or static output.
// RULE_04: Inputs route to all timing destinations.
// RULE_05: Per-destination polarity and edge/level choice.
// RULE_06: Outputs select among seventeen timing sources.
// RULE_07: Filter on pins, trigger bus, star.
// RULE_08: Enabled filter samples every 40 MHz edge.
// RULE_09: Output changes after N matching samples.
// RULE_10: Settings give 5, 257, 101800, disabled.
// RULE_11: Each filtered input has own setting.
// RULE_12: Filters disabled after reset.
// RULE_13: Filter jitter bounded by one clock.
// RULE_14: Direct bus routes bypass the filters.
// RULE_15: Outputs reset to zero, programmable power-up.
// RULE_16: Synchronise first; matching sample restarts count.
// RULE_17: Static output drives bit; input readable.
module pfp_top
  import pfp_pkg::*;
#(
  parameter int LONG_N = PFP_LONG_N
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic [31:0]                  prdata,
  input  wire logic [PFP_NUM_IN-1:0]   programmable_function_pin_in,
  output logic [PFP_NUM_OUT-1:0]       programmable_function_pin_out,
  input  wire logic [PFP_NUM_TRIG-1:0] system_trigger_bus_line_in,
  output logic [PFP_NUM_TRIG-1:0]      system_trigger_bus_line_out,
  output logic [PFP_NUM_TRIG-1:0]      system_trigger_bus_line_oe,
  input  wire logic                    star_trigger_in,
  input  wire logic [PFP_NUM_OUT-1:0]  powerup_level,
  input  wire logic                    hold_complete,
  input  wire logic [1:0]              counter_source,
  input  wire logic [1:0]              counter_gate,
  input  wire logic [1:0]              counter_internal_output,
  input  wire logic                    frequency_output,
  output logic [PFP_NUM_DEST-1:0]      timing_dest
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [PFP_NUM_IN-1:0]              in_mode_reg;
  logic [2*PFP_NUM_IN-1:0]            in_filt_reg;
  logic [2*(PFP_NUM_TRIG+1)-1:0]      trig_filt_reg;
  logic [PFP_NUM_OUT-1:0]             out_timing_reg;
  logic [PFP_NUM_OUT-1:0]             static_output_bit_reg;
  logic [PFP_OSEL_W*PFP_NUM_OUT-1:0]  out_sel_reg;
  logic [PFP_TRT_W*PFP_NUM_TRIG-1:0]  trig_route_reg;
  logic [PFP_NUM_OUT-1:0]             powerup_reg;
  logic                               init_done_reg;
  logic [PFP_DEST_W-1:0]              dest_cfg_reg [PFP_NUM_DEST];
  logic [PFP_NUM_DEST-1:0]            dest_prev_reg;

  // ----------------------------------------------------------------
  // Filters
  // ----------------------------------------------------------------
  // Long setting is a parameter so simulation can shorten it.
  localparam logic [PFP_CW-1:0] LONG_N_W = PFP_CW'(LONG_N);
  wire logic [PFP_NUM_FILT-1:0]   filt_raw =
    {star_trigger_in, system_trigger_bus_line_in, programmable_function_pin_in};
  wire logic [2*PFP_NUM_FILT-1:0] filt_set = {trig_filt_reg, in_filt_reg};
  logic [PFP_NUM_FILT-1:0]        filt_out;

  genvar gi;
  generate
    for (gi = 0; gi < PFP_NUM_FILT; gi++) begin : g_filt
      pfp_filter #(
        .CW      (PFP_CW),
        .SHORT_N (PFP_CW'(PFP_SHORT_N)),
        .MID_N   (PFP_CW'(PFP_MID_N)),
        .LONG_N  (LONG_N_W)
      ) u_filt (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (filt_raw[gi]),
        .setting (filt_set[2*gi +: 2]),  // [RULE_07] [RULE_10] [RULE_11]
        .dout    (filt_out[gi])
      );
    end
  endgenerate

  // Static-mode pins never reach the timing destinations; the trigger bus drive takes the raw pins.
  wire logic [PFP_NUM_IN-1:0]   pin_timing = filt_out[PFP_NUM_IN-1:0] & in_mode_reg; // [RULE_02]
  wire logic [PFP_NUM_TRIG-1:0] trig_f = filt_out[PFP_NUM_IN +: PFP_NUM_TRIG];
  wire logic                    star_f = filt_out[PFP_NUM_FILT-1];
  wire logic [15:0]             dest_src = {1'b0, star_f, trig_f, pin_timing}; // [RULE_04]

  // ----------------------------------------------------------------
  // Destination routing
  // ----------------------------------------------------------------
  generate
    for (gi = 0; gi < PFP_NUM_DEST; gi++) begin : g_dest
      wire logic [3:0] sel  = dest_cfg_reg[gi][PFP_DEST_SRC_LSB +: 4];
      wire logic       inv  = dest_cfg_reg[gi][PFP_DEST_INV_BIT];
      wire logic       edg  = dest_cfg_reg[gi][PFP_DEST_EDG_BIT];
      wire logic       en   = dest_cfg_reg[gi][PFP_DEST_EN_BIT];
      wire logic       lvl  = dest_src[sel] ^ inv;                      // [RULE_05]
      wire logic       nxt  = en & (edg ? (lvl & ~dest_prev_reg[gi]) : lvl); // [RULE_05]
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dest_prev_reg[gi] <= 1'b0;
          timing_dest[gi]   <= 1'b0;
        end else begin
          dest_prev_reg[gi] <= lvl;
          timing_dest[gi]   <= nxt;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output pins and trigger bus drive
  // ----------------------------------------------------------------
  // Trigger lines reach output pins unfiltered; the star trigger does not.
  wire logic [16:0] out_src = {system_trigger_bus_line_in, star_f, frequency_output,
                               counter_internal_output[1], counter_gate[1],
                               counter_source[1], counter_internal_output[0],
                               counter_gate[0], counter_source[0],
                               hold_complete}; // [RULE_06] [RULE_14]
  logic [PFP_NUM_OUT-1:0]  pin_out_next;
  logic [PFP_NUM_TRIG-1:0] trig_out_next;
  logic [PFP_NUM_TRIG-1:0] trig_oe_next;

  generate
    for (gi = 0; gi < PFP_NUM_OUT; gi++) begin : g_out
      wire logic [4:0] osel = out_sel_reg[PFP_OSEL_W*gi +: PFP_OSEL_W];
      wire logic       tval = (osel <= PFP_OSRC_TRIG + 5'h07) ? out_src[osel] : 1'b0;
      assign pin_out_next[gi] = out_timing_reg[gi] ? tval
                                                   : static_output_bit_reg[gi]; // [RULE_03] [RULE_17]
    end
    for (gi = 0; gi < PFP_NUM_TRIG; gi++) begin : g_trig
      wire logic [PFP_TRT_W-1:0] rt = trig_route_reg[PFP_TRT_W*gi +: PFP_TRT_W];
      wire logic [2:0]           pn = rt[PFP_TRT_PIN_W-1:0];
      wire logic                 ok = rt[PFP_TRT_EN_BIT] && (pn < 3'(PFP_NUM_IN));
      assign trig_oe_next[gi]  = ok;
      assign trig_out_next[gi] = ok ? programmable_function_pin_in[pn] : 1'b0; // [RULE_14]
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      programmable_function_pin_out <= '0;  // [RULE_15]
      system_trigger_bus_line_out   <= '0;
      system_trigger_bus_line_oe    <= '0;
    end else begin
      programmable_function_pin_out <= pin_out_next; // [RULE_01]
      system_trigger_bus_line_out   <= trig_out_next;
      system_trigger_bus_line_oe    <= trig_oe_next;
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // One wait state keeps prdata and pready straight from flip-flops.
  wire logic        acc     = psel & penable;
  wire logic        wr_go   = acc & pready & pwrite;
  wire logic        is_dest = (paddr >= PFP_DEST_BASE) &&
                              (paddr < PFP_DEST_BASE + 12'(4 * PFP_NUM_DEST)) &&
                              (paddr[1:0] == 2'h0);
  wire logic [11:0] dest_off = paddr - PFP_DEST_BASE;
  wire logic [4:0]  dest_idx = dest_off[6:2];
  wire logic        hit_in_mode = paddr == PFP_IN_MODE_OFF;
  wire logic        hit_in_filt = paddr == PFP_IN_FILT_OFF;
  wire logic        hit_tr_filt = paddr == PFP_TRIG_FILT_OFF;
  wire logic        hit_out_ctl = paddr == PFP_OUT_CTRL_OFF;
  wire logic        hit_out_sel = paddr == PFP_OUT_SEL_OFF;
  wire logic        hit_tr_rt   = paddr == PFP_TRIG_ROUTE_OFF;
  wire logic        hit_status  = paddr == PFP_STATUS_OFF;
  wire logic        hit_pwrup   = paddr == PFP_POWERUP_OFF;
  wire logic        mapped = hit_in_mode | hit_in_filt | hit_tr_filt | hit_out_ctl |
                             hit_out_sel | hit_tr_rt | hit_status | hit_pwrup | is_dest;
  wire logic        ro_hit = hit_status | hit_pwrup;
  wire logic        err    = ~mapped | (pwrite & ro_hit);
  wire logic [31:0] status_word = {7'h00, programmable_function_pin_out, star_f,
                                   trig_f, filt_out[PFP_NUM_IN-1:0],
                                   programmable_function_pin_in}; // [RULE_17]
  wire logic [31:0] rdata =
    hit_in_mode ? {26'h0, in_mode_reg} :
    hit_in_filt ? {20'h0, in_filt_reg} :
    hit_tr_filt ? {14'h0, trig_filt_reg} :
    hit_out_ctl ? {24'h0, static_output_bit_reg, out_timing_reg} :
    hit_out_sel ? {12'h0, out_sel_reg} :
    hit_tr_rt   ? trig_route_reg :
    hit_status  ? status_word :
    hit_pwrup   ? {28'h0, powerup_reg} :
    is_dest     ? {25'h0, dest_cfg_reg[dest_idx]} : PFP_RESET_VAL;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= PFP_RESET_VAL;
    end else if (acc && !pready) begin
      pready  <= 1'b1;
      pslverr <= err;
      prdata  <= (pwrite || err) ? PFP_RESET_VAL : rdata;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_mode_reg    <= '0;
      in_filt_reg    <= '0;  // [RULE_12]
      trig_filt_reg  <= '0;  // [RULE_12]
      out_timing_reg <= '0;
      out_sel_reg    <= '0;
      trig_route_reg <= '0;
    end else if (wr_go) begin
      if (hit_in_mode) in_mode_reg    <= pwdata[PFP_NUM_IN-1:0];
      if (hit_in_filt) in_filt_reg    <= pwdata[2*PFP_NUM_IN-1:0];       // [RULE_11]
      if (hit_tr_filt) trig_filt_reg  <= pwdata[2*(PFP_NUM_TRIG+1)-1:0]; // [RULE_11]
      if (hit_out_ctl) out_timing_reg <= pwdata[PFP_NUM_OUT-1:0];
      if (hit_out_sel) out_sel_reg    <= pwdata[PFP_OSEL_W*PFP_NUM_OUT-1:0];
      if (hit_tr_rt)   trig_route_reg <= pwdata;
    end
  end

  // Power-up level is caught on the first edge after reset release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      static_output_bit_reg <= '0;  // [RULE_15]
      powerup_reg           <= '0;
      init_done_reg         <= 1'b0;
    end else if (!init_done_reg) begin
      static_output_bit_reg <= powerup_level;  // [RULE_15]
      powerup_reg           <= powerup_level;
      init_done_reg         <= 1'b1;
    end else if (wr_go && hit_out_ctl) begin
      static_output_bit_reg <= pwdata[2*PFP_NUM_OUT-1:PFP_NUM_OUT]; // [RULE_17]
    end
  end

  generate
    for (gi = 0; gi < PFP_NUM_DEST; gi++) begin : g_dcfg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dest_cfg_reg[gi] <= '0;
        end else if (wr_go && is_dest && (dest_idx == 5'(gi))) begin
          dest_cfg_reg[gi] <= pwdata[PFP_DEST_W-1:0]; // [RULE_04]
        end
      end
    end
  endgenerate

  // Filter jitter is one 25 ns clock at every setting, inside all bounds. [RULE_13]
endmodule

// file: test/pfp_checker.sv
// Checker for bus timing and power-up levels of the function pin block.
module pfp_checker
  import pfp_pkg::*;
(
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [11:0]             paddr,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic [31:0]             prdata,
  input wire logic [PFP_NUM_OUT-1:0]  powerup_level,
  input wire logic [PFP_NUM_OUT-1:0]  programmable_function_pin_out,
  input wire logic [PFP_NUM_DEST-1:0] timing_dest
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------
  // Decode
  // ------
  wire acc = psel && penable;
  wire ro  = paddr == PFP_STATUS_OFF || paddr == PFP_POWERUP_OFF;
  wire map = paddr[1:0] == 2'h0 &&
             (paddr < 12'h020 || (paddr >= PFP_DEST_BASE && paddr < 12'h160));
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------
  // Properties
  // ------
  a_ready_wait: assert property (acc && !pready |=> pready)
    else $error("no answer one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ready_cause: assert property (pready |-> acc && $past(acc))
    else $error("ready without a pending access");
  a_write_quiet: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
    else $error("read data not zero on a write");
  a_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error without ready or with data");
  a_ro_refused: assert property (pready && pwrite && ro |-> pslverr)
    else $error("write to read-only word accepted");
  a_hole_refused: assert property (pready && !map |-> pslverr)
    else $error("unmapped word accepted");
  a_map_ok: assert property (pready && map && !(pwrite && ro) |-> !pslverr)
    else $error("mapped access refused");
  a_reset_zero: assert property ($rose(presetn) |->
      programmable_function_pin_out == 4'h0 && timing_dest == 24'h000000)
    else $error("outputs not zero out of reset");
  a_powerup_out: assert property ($rose(presetn) |->
      ##2 programmable_function_pin_out == $past(powerup_level, 2))
    else $error("pins miss their power-up level");
  c_err: cover property (pready && pslverr);
  c_read: cover property (pready && !pwrite && !pslverr);
  c_dest: cover property ($rose(timing_dest[0]));
endmodule

bind pfp_top pfp_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pready, .pslverr, .prdata, .powerup_level, .programmable_function_pin_out, .timing_dest);

// file: test/pfp_ext_model.sv
// External sources and trigger bus wiring facing the function pins.
module pfp_ext_model
  import pfp_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic [PFP_NUM_IN-1:0]   pin_req,
  input  wire logic [PFP_NUM_TRIG-1:0] trig_req,
  input  wire logic                    star_req,
  input  wire logic [PFP_NUM_TRIG-1:0] trig_out,
  input  wire logic [PFP_NUM_TRIG-1:0] trig_oe,
  output logic [PFP_NUM_IN-1:0]        pin_drv,
  output logic                         star_drv,
  output logic [PFP_NUM_TRIG-1:0]      trig_wire
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [PFP_NUM_TRIG-1:0] trig_drv;
  // ------
  // Sources
  // ------
  initial begin
    pin_drv = 6'h00;
    star_drv = 1'b0;
    trig_drv = 8'h00;
  end
  // Sources move just after an edge, so the block never sees a mid-cycle change.
  always @(posedge pclk) begin
    pin_drv <= pin_req;
    trig_drv <= trig_req;
    star_drv <= star_req;
  end
  // The block wins a bus line while it drives it; the source sets it otherwise.
  assign trig_wire = (trig_oe & trig_out) | (~trig_oe & trig_drv);
endmodule

// file: test/pfp_top_tb.sv
// Self-checking bench for the function pin block.
module pfp_top_tb
  import pfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LN = 20;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic [5:0]  pin_req = 6'h00;
  logic [5:0]  pin_drv;
  logic        star_drv;
  logic [7:0]  trig_wire;
  logic [7:0]  trig_out;
  logic [7:0]  trig_oe;
  logic [16:0] src = 17'h00000;
  logic [3:0]  pout;
  logic [23:0] dest;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          l;
  // A disabled filter passes each sample on, so it is timed as one sample.
  int          nt[4] = '{1, 5, 257, LN};
  logic [3:0]  pwr_lvl = 4'hA;
  // ------
  // Harness
  // ------
  always #12.5 pclk = ~pclk;
  pfp_top #(.LONG_N(LN)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .prdata, .programmable_function_pin_in(pin_drv),
    .programmable_function_pin_out(pout), .system_trigger_bus_line_in(trig_wire),
    .system_trigger_bus_line_out(trig_out), .system_trigger_bus_line_oe(trig_oe),
    .star_trigger_in(star_drv), .powerup_level(pwr_lvl), .hold_complete(src[0]),
    .counter_source({src[4], src[1]}), .counter_gate({src[5], src[2]}),
    .counter_internal_output({src[6], src[3]}), .frequency_output(src[7]),
    .timing_dest(dest));
  pfp_ext_model u_ext (.pclk, .pin_req, .trig_req(src[16:9]), .star_req(src[8]),
    .trig_out, .trig_oe, .pin_drv, .star_drv, .trig_wire);
  // ------
  // Tasks
  // ------
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // The request stands until the rising edge at which pready is seen high.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic lat(input int b, input logic v, input int mx);
    for (l = 1; l <= mx; l++) begin
      @(negedge pclk);
      if (dest[b] === v) break;
    end
  endtask
  // ------
  // Tests
  // ------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(negedge pclk);
    check(32'(pout), 32'hA);
    rchk(PFP_IN_FILT_OFF, 32'h0);
    rchk(PFP_TRIG_FILT_OFF, 32'h0);
    rchk(PFP_POWERUP_OFF, 32'hA);
    $display("test reset done");
    wr(PFP_IN_MODE_OFF, 32'h29);
    wr(PFP_DEST_BASE, 32'h40);
    for (int s = 0; s < 4; s++) begin
      wr(PFP_IN_FILT_OFF, 32'(s) | (32'(3 - s) << 2));
      rchk(PFP_IN_FILT_OFF, 32'(s) | (32'(3 - s) << 2));
      if (s != 0) begin
        repeat (2) begin
          @(posedge pclk);
          pin_req <= 6'h01;
          repeat (nt[s] - 1) @(posedge pclk);
          pin_req <= 6'h00;
        end
        lat(0, 1'b1, nt[s] + 12);
        check(32'(l), 32'(nt[s] + 13));
      end
      for (int v = 1; v >= 0; v--) begin
        @(posedge pclk);
        pin_req <= 6'(v);
        lat(0, v[0], nt[s] + 12);
        check(32'(l >= nt[s] + 4 && l <= nt[s] + 5), 32'h1);
      end
    end
    $display("test filter done");
    wr(PFP_DEST_BASE + 12'h004, 32'h53);
    wr(PFP_DEST_BASE + 12'h008, 32'h63);
    wr(PFP_DEST_BASE + 12'h00C, 32'h44);
    repeat (6) @(negedge pclk);
    check(32'(dest[3:1]), 32'h1);
    @(posedge pclk);
    pin_req <= 6'h18;
    lat(2, 1'b1, 12);
    @(negedge pclk);
    check(32'({l < 13, dest[3:1]}), 32'h8);
    $display("test routing modes done");
    wr(PFP_OUT_CTRL_OFF, 32'h50);
    @(posedge pclk);
    pin_req <= 6'h2D;
    repeat (30) @(negedge pclk);
    check(32'(pout), 32'h5);
    rchk(PFP_STATUS_OFF, {7'h00, 4'h5, 9'h000, 6'h2D, 6'h2D});
    xfer(1'b1, PFP_STATUS_OFF, 32'hFFFF_FFFF);
    check(32'(err), 32'h1);
    xfer(1'b0, 12'h020, 32'h0);
    check(32'(err), 32'h1);
    pin_req <= 6'h00;
    $display("test static bits done");
    wr(PFP_TRIG_FILT_OFF, 32'h3);
    wr(PFP_OUT_CTRL_OFF, 32'h1);
    for (int k = 0; k < 17; k++) begin
      wr(PFP_OUT_SEL_OFF, 32'(k));
      for (int v = 1; v >= 0; v--) begin
        @(posedge pclk);
        src <= 17'(v) << k;
        repeat (6) @(negedge pclk);
        check(32'(pout), 32'(v));
      end
    end
    $display("test output select done");
    wr(PFP_IN_FILT_OFF, 32'h30);
    wr(PFP_TRIG_ROUTE_OFF, 32'hA);
    @(posedge pclk);
    pin_req <= 6'h04;
    repeat (3) @(negedge pclk);
    check(32'({trig_oe, trig_out}), 32'h0101);
    for (int d = 0; d < 24; d++) wr(PFP_DEST_BASE + 12'(4 * d), 32'h45);
    @(posedge pclk);
    pin_req <= 6'h20;
    repeat (6) @(negedge pclk);
    check(32'(dest), 32'h00FF_FFFF);
    $display("test bus and destinations done");
    @(posedge pclk);
    pwr_lvl <= 4'h5;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(negedge pclk);
    check(32'(pout), 32'h5);
    rchk(PFP_IN_FILT_OFF, 32'h0);
    rchk(PFP_POWERUP_OFF, 32'h5);
    $display("test second reset done");
    report_and_stop();
  end
endmodule
